// ---- rtl/swe_device.sv ----
// Purpose: Device end: power states, wake source masking and wake status.
// Assumes: ref_clk always runs; gpio pins and bus power sense are asynchronous.
// Notes: MAC matchers and PHY detectors are outside; their events arrive as pulses.
// Contract
// - Suspend with select 11b enters level three.
// - Level three keeps every clock running.
// - Level three wakes on gpio, link-up, good frame.
// - Good frame wake sets LAN status bit.
// - Any LAN enable in level three drops frames.
// - Host keeps LAN enables clear in level three.
// - Host reads link-up select to classify GPIO7.
// - Levels zero and one wake sources, no bus-power.
// - Level two host/gpio; unpowered only bus-power.
// - GPIO wake sets per-pin status bits 0-10.
// - Pending event at suspend wakes immediately.
// - Good frame needs no LAN enable set.
// - GPIO7 wakes on link-up instead of its pin when selected, in levels zero and three only.
// - GPIO 0-7 wake only with internal PHY.
// - GPIO 8-10 wake in either PHY mode.
// - Five enables gate events into composite LAN wake.
// - Host reads exited level to disambiguate LAN status.
// - Level encodings 00,01,10,11; default 10.
// - Bus reset returns to normal state.
// - Internal wake event raises remote wake.
module swe_device
    import swe_pkg::*;
#(
    parameter int GPIO_W = SWE_GPIO_W
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    swe_link_if.dev link,
    input wire logic [GPIO_W-1:0] gpio_pin,
    input wire logic [GPIO_W-1:0] gpio_pol,
    input wire logic bus_power_sense,
    input wire logic [SWE_LAN_EN_W-1:0] lan_events,
    input wire logic good_frame_rx,
    input wire logic energy_detect,
    input wire logic link_up,
    output logic [1:0] power_state,
    output logic remote_wake_out
);

    if (GPIO_W != SWE_GPIO_W) begin : g_bad_width
        $error("GPIO_W must match the package pin count");
    end

    // --------
    // State record
    // --------
    typedef struct packed {
        logic [GPIO_W-1:0] gpio_s1;
        logic [GPIO_W-1:0] gpio_s2;
        logic [GPIO_W-1:0] gpio_prev;
        logic vbus_s1;
        logic vbus_s2;
        swe_pstate_t pst;
        logic [1:0] level;
        logic [1:0] exited;
        logic [GPIO_W-1:0] gflags;
        logic [1:0] wstat;
        logic rwake;
        logic clk_on;
        logic drop;
        logic [1:0] pst_out;
    } swe_dev_t;

    swe_dev_t st_ff;
    swe_dev_t nxt_st;

    // Classifies the power state for the link.
    function automatic logic [1:0] swe_code(input swe_pstate_t p);
        case (p)
            SWE_UNPOWERED: swe_code = 2'h0;
            SWE_NORMAL: swe_code = 2'h1;
            default: swe_code = 2'h2;
        endcase
    endfunction

    logic [GPIO_W-1:0] gpio_act;
    logic [GPIO_W-1:0] gpio_evt;
    logic lan_comp;
    logic good_evt;
    logic any_lan_en;
    logic in_susp;
    logic wake_ev;
    logic pending;

    // --------
    // Wake event decode
    // --------
    always_comb begin
        any_lan_en = |link.lan_wake_en;
        lan_comp = |(link.lan_wake_en & lan_events);
        good_evt = good_frame_rx && !any_lan_en;
        gpio_act = st_ff.gpio_s2 ^ gpio_pol;
        gpio_evt = gpio_act & ~st_ff.gpio_prev & link.gpio_wake_en;
        if (link.link_up_wake_select) begin
            gpio_evt[SWE_GPIO_LINK] = link_up && link.gpio_wake_en[SWE_GPIO_LINK]
                && (st_ff.level == SWE_LVL_ZERO || st_ff.level == SWE_LVL_THREE);
        end
        if (!link.int_ext_phy) begin
            gpio_evt[SWE_GPIO_INT_TOP:0] = '0;
        end
        // Lines 8-10 pass in either PHY mode.
        in_susp = (st_ff.pst == SWE_SUSPENDED);
        if (!in_susp) begin
            gpio_evt = '0;
        end
        wake_ev = 1'b0;
        case (st_ff.level)
            SWE_LVL_ZERO: wake_ev = (link.lan_wake_enable && lan_comp) || (|gpio_evt);
            SWE_LVL_ONE: wake_ev = (link.energy_wake_en && energy_detect) || (|gpio_evt);
            SWE_LVL_TWO: wake_ev = |gpio_evt;
            SWE_LVL_THREE: wake_ev = good_evt || (|gpio_evt);
            default: wake_ev = 1'b0;
        endcase
        wake_ev = wake_ev && in_susp;
        pending = (|st_ff.gflags) || (|st_ff.wstat);
    end

    // --------
    // Next state
    // --------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.gpio_s1 = gpio_pin;
        nxt_st.gpio_s2 = st_ff.gpio_s1;
        nxt_st.gpio_prev = gpio_act;
        nxt_st.vbus_s1 = bus_power_sense;
        nxt_st.vbus_s2 = st_ff.vbus_s1;
        nxt_st.rwake = 1'b0;
        nxt_st.level = link.level_sel;
        // Status: set wins over a clear in the same cycle.
        nxt_st.gflags = (st_ff.gflags & ~link.gpio_clr) | gpio_evt;
        nxt_st.wstat = st_ff.wstat & ~link.wake_clr;
        if (in_susp && st_ff.level == SWE_LVL_ZERO && link.lan_wake_enable && lan_comp) begin
            nxt_st.wstat[SWE_WS_LAN] = 1'b1;
        end
        if (in_susp && st_ff.level == SWE_LVL_THREE && good_evt) begin
            nxt_st.wstat[SWE_WS_LAN] = 1'b1;
        end
        if (in_susp && st_ff.level == SWE_LVL_ONE && link.energy_wake_en && energy_detect) begin
            nxt_st.wstat[SWE_WS_ED] = 1'b1;
        end
        case (st_ff.pst)
            SWE_UNPOWERED: begin
                if (st_ff.vbus_s2) begin
                    nxt_st.pst = SWE_NORMAL;
                end
            end
            SWE_NORMAL: begin
                if (link.suspend_req) begin
                    nxt_st.pst = SWE_SUSPENDED;
                    nxt_st.level = link.level_sel;
                    if (pending) begin
                        nxt_st.pst = SWE_NORMAL;
                        nxt_st.rwake = 1'b1;
                        nxt_st.exited = link.level_sel;
                    end
                end
            end
            SWE_SUSPENDED: begin
                nxt_st.level = st_ff.level;
                if (link.resume_req || wake_ev) begin
                    nxt_st.pst = SWE_NORMAL;
                    nxt_st.exited = st_ff.level;
                    nxt_st.rwake = wake_ev;
                end
            end
            default: nxt_st.pst = SWE_NORMAL;
        endcase
        if (link.bus_reset && st_ff.pst != SWE_UNPOWERED) begin
            nxt_st.pst = SWE_NORMAL;
            nxt_st.gflags = '0;
            nxt_st.wstat = '0;
        end
        if (!st_ff.vbus_s2) begin
            nxt_st.pst = SWE_UNPOWERED;
        end
        // Clocks stop in levels zero to two and when unpowered.
        nxt_st.clk_on = !(nxt_st.pst == SWE_SUSPENDED && nxt_st.level != SWE_LVL_THREE)
            && nxt_st.pst != SWE_UNPOWERED;
        nxt_st.drop = nxt_st.pst == SWE_SUSPENDED && nxt_st.level == SWE_LVL_THREE
            && any_lan_en;
        nxt_st.pst_out = swe_code(nxt_st.pst);
    end

    // --------
    // State register
    // --------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{gpio_s1: '0, gpio_s2: '0, gpio_prev: '0, vbus_s1: 1'b0,
                vbus_s2: 1'b0, pst: SWE_UNPOWERED, level: SWE_LVL_RESET,
                exited: SWE_LVL_RESET, gflags: '0, wstat: 2'h0, rwake: 1'b0,
                clk_on: 1'b0, drop: 1'b0, pst_out: 2'h0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs come straight from the state record.
    assign link.power_state = st_ff.pst_out;
    assign link.exited_level = st_ff.exited;
    assign link.gpio_wake_flags = st_ff.gflags;
    assign link.wake_status_field = st_ff.wstat;
    assign link.remote_wake = st_ff.rwake;
    assign link.clocks_on = st_ff.clk_on;
    assign link.frame_drop = st_ff.drop;
    assign power_state = st_ff.pst_out;
    assign remote_wake_out = st_ff.rwake;

endmodule

// ---- rtl/swe_pkg.sv ----
// Purpose: Shared constants and types for the suspend wake event control block.
// Assumes: One always-running reference clock; all inputs synchronous except pins.
// Notes: Shared by the device end, the host end, the link properties and the bench.
package swe_pkg;

    // --------
    // Suspend-level select encodings
    // --------
    localparam logic [1:0] SWE_LVL_ZERO = 2'h0;
    localparam logic [1:0] SWE_LVL_ONE = 2'h1;
    localparam logic [1:0] SWE_LVL_TWO = 2'h2;
    localparam logic [1:0] SWE_LVL_THREE = 2'h3;
    localparam logic [1:0] SWE_LVL_RESET = SWE_LVL_TWO;

    // --------
    // Field layout and widths
    // --------
    localparam int SWE_GPIO_W = 11;
    localparam int SWE_GPIO_LINK = 7;
    localparam int SWE_GPIO_INT_TOP = 7;
    localparam int SWE_LAN_EN_W = 5;
    localparam int SWE_WS_LAN = 1;
    localparam int SWE_WS_ED = 0;
    localparam logic [7:0] SWE_A_CTRL = 8'h00;
    localparam logic [7:0] SWE_A_GPIO = 8'h04;
    localparam logic [7:0] SWE_A_CMD = 8'h08;
    localparam logic [7:0] SWE_A_STAT = 8'h0c;
    localparam logic [7:0] SWE_A_GSTAT = 8'h10;

    // Power states of the device.
    typedef enum logic [2:0] {
        SWE_UNPOWERED,
        SWE_NORMAL,
        SWE_SUSPENDED
    } swe_pstate_t;

endpackage

// ---- rtl/swe_link_if.sv ----
// Purpose: Link between the USB host side and the device wake logic.
// Assumes: Both ends run on ref_clk.
// Notes: Levels unless stated; pulses are one cycle wide.
interface swe_link_if;
    logic [1:0] level_sel;     // Suspend-level select, host driven.
    logic suspend_req;         // Pulse: suspend signalling.
    logic resume_req;          // Pulse: host resume signalling.
    logic bus_reset;           // Pulse: USB bus reset.
    logic [4:0] lan_wake_en;   // Per-event LAN wake enables.
    logic lan_wake_enable;     // Global LAN wake enable.
    logic energy_wake_en;      // Energy-detect wake enable.
    logic [10:0] gpio_wake_en; // Per-pin wake enables.
    logic link_up_wake_select; // GPIO7 used for link-up.
    logic int_ext_phy;         // High when the internal PHY is selected.
    logic [10:0] gpio_clr;     // Pulse: clear matching gpio flags.
    logic [1:0] wake_clr;      // Pulse: clear wake status bits.
    logic [1:0] power_state;   // Device: 0 unpowered, 1 normal, 2 suspended.
    logic [1:0] exited_level;  // Device: level last exited.
    logic [10:0] gpio_wake_flags; // Device: sticky gpio wake status.
    logic [1:0] wake_status_field; // Device: [1] LAN, [0] energy detect.
    logic remote_wake;         // Device: pulse toward the host.
    logic clocks_on;           // Device: internal clocks enabled.
    logic frame_drop;          // Device: drop received frames.

    modport dev (
        input level_sel, suspend_req, resume_req, bus_reset, lan_wake_en, lan_wake_enable,
        input energy_wake_en, gpio_wake_en, link_up_wake_select, int_ext_phy, gpio_clr,
        input wake_clr,
        output power_state, exited_level, gpio_wake_flags, wake_status_field, remote_wake,
        output clocks_on, frame_drop
    );
    modport host (
        output level_sel, suspend_req, resume_req, bus_reset, lan_wake_en, lan_wake_enable,
        output energy_wake_en, gpio_wake_en, link_up_wake_select, int_ext_phy, gpio_clr,
        output wake_clr,
        input power_state, exited_level, gpio_wake_flags, wake_status_field, remote_wake,
        input clocks_on, frame_drop
    );
endinterface

// ---- rtl/swe_host.sv ----
// Purpose: Host end: APB registers driving suspend, resume and wake setup.
// Assumes: APB slave with zero wait states; ref_clk shared with the device.
// Notes: Register map at offsets 0x00..0x10.
module swe_host
    import swe_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    swe_link_if.host link
);

    // --------
    // State record
    // --------
    typedef struct packed {
        logic [1:0] level;
        logic [4:0] lan_en;
        logic lan_gen;
        logic ed_en;
        logic int_phy;
        logic link_sel;
        logic [10:0] gen;
        logic susp;
        logic res;
        logic brst;
        logic [10:0] gclr;
        logic [1:0] wclr;
        logic [31:0] rdata;
        logic err;
    } swe_host_t;

    swe_host_t st_ff;
    swe_host_t nxt_st;
    logic acc;
    logic wr;

    // --------
    // Register access
    // --------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.susp = 1'b0;
        nxt_st.res = 1'b0;
        nxt_st.brst = 1'b0;
        nxt_st.gclr = '0;
        nxt_st.wclr = '0;
        nxt_st.err = 1'b0;
        acc = psel && !penable;
        wr = psel && penable && pwrite;
        if (acc || wr) begin
            nxt_st.rdata = 32'h0;
            case (paddr)
                SWE_A_CTRL: begin
                    nxt_st.rdata = {22'h0, st_ff.int_phy, st_ff.ed_en, st_ff.lan_gen,
                        st_ff.lan_en, st_ff.level};
                    if (wr) begin
                        nxt_st.level = pwdata[1:0];
                        nxt_st.lan_en = pwdata[6:2];
                        nxt_st.lan_gen = pwdata[7];
                        nxt_st.ed_en = pwdata[8];
                        nxt_st.int_phy = pwdata[9];
                    end
                end
                SWE_A_GPIO: begin
                    nxt_st.rdata = {20'h0, st_ff.link_sel, st_ff.gen};
                    if (wr) begin
                        nxt_st.gen = pwdata[10:0];
                        nxt_st.link_sel = pwdata[11];
                    end
                end
                SWE_A_CMD: begin
                    if (wr) begin
                        nxt_st.susp = pwdata[0];
                        nxt_st.res = pwdata[1];
                        nxt_st.brst = pwdata[2];
                    end
                end
                SWE_A_STAT: begin
                    nxt_st.rdata = {26'h0, link.exited_level, link.wake_status_field,
                        link.power_state};
                    if (wr) begin
                        nxt_st.wclr = pwdata[3:2];
                    end
                end
                SWE_A_GSTAT: begin
                    nxt_st.rdata = {21'h0, link.gpio_wake_flags};
                    if (wr) begin
                        nxt_st.gclr = pwdata[10:0];
                    end
                end
                default: nxt_st.err = acc;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{level: SWE_LVL_RESET, lan_en: 5'h0, lan_gen: 1'b0, ed_en: 1'b0,
                int_phy: 1'b1, link_sel: 1'b0, gen: 11'h0, susp: 1'b0, res: 1'b0,
                brst: 1'b0, gclr: 11'h0, wclr: 2'h0, rdata: 32'h0, err: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Bus answers in the access cycle after setup.
    assign pready = 1'b1;
    assign prdata = st_ff.rdata;
    assign pslverr = st_ff.err;
    // Software keeps lan_en clear before selecting level three.
    assign link.level_sel = st_ff.level;
    assign link.suspend_req = st_ff.susp;
    assign link.resume_req = st_ff.res;
    assign link.bus_reset = st_ff.brst;
    assign link.lan_wake_en = st_ff.lan_en;
    assign link.lan_wake_enable = st_ff.lan_gen;
    assign link.energy_wake_en = st_ff.ed_en;
    assign link.gpio_wake_en = st_ff.gen;
    assign link.link_up_wake_select = st_ff.link_sel;
    assign link.int_ext_phy = st_ff.int_phy;
    assign link.gpio_clr = st_ff.gclr;
    assign link.wake_clr = st_ff.wclr;

endmodule

// ---- sim/swe_link_properties.sv ----
// Purpose: Concurrent checks on the link between the host end and the device end.
// Assumes: One clock domain, ref_clk, with asynchronous active-low rst_n.
// Notes: Instantiated beside the link interface by the bench top module.
module swe_link_properties
    import swe_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [1:0] level_sel,
    input wire logic suspend_req,
    input wire logic resume_req,
    input wire logic bus_reset,
    input wire logic [4:0] lan_wake_en,
    input wire logic [1:0] power_state,
    input wire logic [10:0] gpio_wake_flags,
    input wire logic [1:0] wake_status_field,
    input wire logic remote_wake,
    input wire logic clocks_on,
    input wire logic frame_drop
);
    timeunit 1ns;
    timeprecision 1ns;

    // --------
    // Suspend level tracking
    // --------
    logic [1:0] susp_lvl_ff;
    logic [1:0] nxt_susp_lvl;

    // Remembers the level that was selected when suspend signalling came.
    always_comb begin
        nxt_susp_lvl = suspend_req ? level_sel : susp_lvl_ff;
    end

    // Registers the remembered level.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            susp_lvl_ff <= 2'h0;
        end else begin
            susp_lvl_ff <= nxt_susp_lvl;
        end
    end

    // --------
    // Properties
    // --------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    chk_suspend_enter: assert property (
        suspend_req && power_state == 2'h1 && gpio_wake_flags == 11'h0
        && wake_status_field == 2'h0 |=> power_state == 2'h2)
        else $error("suspend signalling did not suspend the device");
    chk_pending_wake: assert property (
        suspend_req && power_state == 2'h1 && gpio_wake_flags != 11'h0
        |=> power_state == 2'h1 ##[0:3] remote_wake)
        else $error("pending flag did not wake at once");
    chk_level3_clocks: assert property (
        power_state == 2'h2 && $stable(power_state) && susp_lvl_ff == SWE_LVL_THREE
        |-> clocks_on)
        else $error("clocks stopped in the highest suspend level");
    chk_frame_drop: assert property (
        power_state == 2'h2 && $stable(power_state) && susp_lvl_ff == SWE_LVL_THREE
        && lan_wake_en != 5'h0 |-> frame_drop)
        else $error("frames kept with lan enables in level three");
    chk_level_default: assert property (
        $rose(rst_n) |-> level_sel == SWE_LVL_RESET)
        else $error("level select does not reset to level two");
    chk_resume_normal: assert property (
        resume_req && power_state == 2'h2 |-> ##[1:3] power_state == 2'h1)
        else $error("resume did not return to normal");
    chk_bus_reset: assert property (
        bus_reset && power_state != 2'h0
        |-> ##[1:3] (power_state == 2'h1 && wake_status_field == 2'h0))
        else $error("bus reset did not reinitialise the device");
    chk_wake_pulse: assert property (
        remote_wake |-> power_state == 2'h1 ##1 !remote_wake)
        else $error("remote wake not a single pulse in normal state");
    chk_unpowered_quiet: assert property (
        power_state == 2'h0 |-> !remote_wake)
        else $error("remote wake raised while unpowered");

    cov_level_three: cover property (power_state == 2'h2 && susp_lvl_ff == SWE_LVL_THREE);
    cov_remote_wake: cover property (remote_wake);
    cov_reset_suspended: cover property (bus_reset && power_state == 2'h2);
endmodule

// ---- sim/test_suspend_wake_event_control.sv ----
// Purpose: Self-checking bench driving the host end over APB and the device pins.
// Assumes: Both ends share ref_clk at 20 MHz; pin polarity tied active high.
// Notes: Each do_case scenario suspends, fires one source and reads status back.
module test_suspend_wake_event_control
    import swe_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // --------
    // Signals and instances
    // --------
    logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, rd_err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_data;
    logic [10:0] gpio_pin;
    logic bus_power_sense, good_frame_rx, energy_detect, link_up, rwake;
    logic [4:0] lan_events;
    logic [1:0] dev_state;
    int fails;
    int tests_run;

    swe_link_if swe_link_if_inst ();
    swe_host swe_host_inst (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(swe_link_if_inst));
    swe_device swe_device_inst (.ref_clk(ref_clk), .rst_n(rst_n), .link(swe_link_if_inst),
        .gpio_pin(gpio_pin), .gpio_pol(11'h000), .bus_power_sense(bus_power_sense),
        .lan_events(lan_events), .good_frame_rx(good_frame_rx),
        .energy_detect(energy_detect), .link_up(link_up), .power_state(dev_state),
        .remote_wake_out(rwake));
    swe_link_properties swe_link_properties_inst (.ref_clk(ref_clk), .rst_n(rst_n),
        .level_sel(swe_link_if_inst.level_sel), .suspend_req(swe_link_if_inst.suspend_req),
        .resume_req(swe_link_if_inst.resume_req), .bus_reset(swe_link_if_inst.bus_reset),
        .lan_wake_en(swe_link_if_inst.lan_wake_en), .power_state(swe_link_if_inst.power_state),
        .gpio_wake_flags(swe_link_if_inst.gpio_wake_flags),
        .wake_status_field(swe_link_if_inst.wake_status_field),
        .remote_wake(swe_link_if_inst.remote_wake), .clocks_on(swe_link_if_inst.clocks_on),
        .frame_drop(swe_link_if_inst.frame_drop));

    // --------
    // Shared tasks
    // --------
    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Compares one word and reports a mismatch at once.
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // Compares one flag and reports a mismatch at once.
    task automatic check_flag(input logic got, input logic exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: %s got %b expected %b", $time, msg, got, exp);
        end
    endtask

    // One APB transfer; read data and error are taken at the edge that sees pready.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Fires one source: 0 pins only, 1 energy, 2 link-up, 3 good frame, 8+k lan event k.
    task automatic fire(input int ev, input logic [10:0] pins);
        @(posedge ref_clk);
        gpio_pin <= pins;
        lan_events <= (ev >= 8) ? 5'(1 << (ev - 8)) : 5'h00;
        energy_detect <= (ev == 1);
        link_up <= (ev == 2);
        good_frame_rx <= (ev == 3);
        @(posedge ref_clk);
        lan_events <= 5'h00;
        energy_detect <= 1'b0;
        link_up <= 1'b0;
        good_frame_rx <= 1'b0;
    endtask

    // Suspends at one level, fires a source, then checks state, status and flags.
    task automatic do_case(input logic [1:0] lvl, input logic [31:0] ctl, input logic [31:0] gr,
        input logic [10:0] pins, input int ev, input logic [5:0] st, input logic [10:0] fl);
        apb(1'b1, 8'h00, ctl | {30'h0, lvl});
        apb(1'b1, 8'h04, gr);
        apb(1'b1, 8'h08, 32'h1);
        apb(1'b0, 8'h0c, 32'h0);
        check_word(rd_data & 32'h3, 32'h2, "suspend entry");
        if (lvl == SWE_LVL_THREE) begin
            check_flag(swe_link_if_inst.clocks_on, 1'b1, "clocks in level three");
        end
        fire(ev, pins);
        for (int i = 0; i < 12 && dev_state !== 2'h1; i++) begin
            @(posedge ref_clk);
        end
        check_flag(rwake, st[1:0] == 2'h1, "remote wake pulse");
        apb(1'b0, 8'h0c, 32'h0);
        check_word(rd_data & (st[1:0] == 2'h1 ? 32'h3f : 32'h0f), {26'h0, st}, "status");
        apb(1'b0, 8'h10, 32'h0);
        check_word(rd_data, {21'h0, fl}, "gpio flags");
        gpio_pin <= 11'h000;
        if (dev_state !== 2'h1) begin
            apb(1'b1, 8'h08, 32'h2);
        end
        apb(1'b1, 8'h10, 32'h7ff);
        apb(1'b1, 8'h0c, 32'hc);
        apb(1'b1, 8'h00, 32'h200);
        apb(1'b1, 8'h04, 32'h0);
    endtask

    // --------
    // Scenarios
    // --------
    // Defaults, unmapped access, and leaving the unpowered state on bus power.
    task automatic t_defaults();
        apb(1'b0, 8'h00, 32'h0);
        check_word(rd_data, 32'h202, "control defaults");
        apb(1'b0, 8'hf0, 32'h0);
        check_flag(rd_err, 1'b1, "unmapped access error");
        apb(1'b0, 8'h0c, 32'h0);
        check_word(rd_data & 32'h3, 32'h0, "unpowered at start");
        bus_power_sense <= 1'b1;
        repeat (3) @(posedge ref_clk);
        apb(1'b0, 8'h0c, 32'h0);
        check_word(rd_data & 32'hf, 32'h1, "normal after bus power");
    endtask

    // Every source at every suspend level against the permitted-source map.
    task automatic t_wake_table();
        logic [4:0] wmap [4] = '{5'b01011, 5'b00101, 5'b00001, 5'b11001};
        logic [31:0] ctl [5] = '{32'h200, 32'h284, 32'h300, 32'h200, 32'h200};
        logic [31:0] gr [5] = '{32'h200, 32'h0, 32'h0, 32'h880, 32'h0};
        logic [1:0] sb [5] = '{2'b00, 2'b10, 2'b01, 2'b00, 2'b10};
        logic [10:0] fl [5] = '{11'h200, 11'h0, 11'h0, 11'h080, 11'h0};
        int evs [5] = '{0, 8, 1, 2, 3};
        logic w;
        for (int l = 0; l < 4; l++) begin
            for (int s = 0; s < 5; s++) begin
                w = wmap[l][s];
                do_case(2'(l), ctl[s], gr[s], (s == 0) ? 11'h200 : 11'h0, evs[s],
                    w ? {2'(l), sb[s], 2'h1} : 6'h02, w ? fl[s] : 11'h0);
            end
        end
    endtask

    // Each of the five lan enables, a mismatched event, and enables in level three.
    task automatic t_lan_enables();
        for (int k = 0; k < 5; k++) begin
            do_case(2'h0, 32'h280 | (32'h4 << k), 32'h0, 11'h0, 8 + k, 6'h09, 11'h0);
        end
        do_case(2'h0, 32'h284, 32'h0, 11'h0, 9, 6'h02, 11'h0);
        do_case(2'h3, 32'h284, 32'h0, 11'h0, 3, 6'h02, 11'h0);
    endtask

    // Low pins need the internal PHY; high pins wake in either mode.
    task automatic t_phy_mode();
        do_case(2'h2, 32'h0, 32'h8, 11'h008, 0, 6'h02, 11'h0);
        do_case(2'h2, 32'h0, 32'h400, 11'h400, 0, 6'h21, 11'h400);
    endtask

    // A flag left pending at suspend keeps the device awake.
    task automatic t_pending();
        apb(1'b1, 8'h04, 32'h200);
        apb(1'b1, 8'h08, 32'h1);
        fire(0, 11'h200);
        repeat (4) @(posedge ref_clk);
        gpio_pin <= 11'h000;
        apb(1'b1, 8'h08, 32'h1);
        apb(1'b0, 8'h0c, 32'h0);
        check_word(rd_data & 32'h3, 32'h1, "pending flag wakes at once");
        apb(1'b1, 8'h10, 32'h7ff);
        apb(1'b1, 8'h04, 32'h0);
    endtask

    // Bus reset while suspended returns the device to normal with status clear.
    task automatic t_bus_reset();
        apb(1'b1, 8'h08, 32'h1);
        apb(1'b1, 8'h08, 32'h4);
        apb(1'b0, 8'h0c, 32'h0);
        check_word(rd_data & 32'hf, 32'h1, "bus reset from suspend");
    endtask

    // --------
    // Clock, main sequence and watchdog
    // --------
    // Free-running reference clock.
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // Resets, then runs every scenario in turn.
    initial begin
        {rst_n, psel, penable, pwrite, bus_power_sense} = 5'h0;
        {good_frame_rx, energy_detect, link_up} = 3'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        gpio_pin = 11'h000;
        lan_events = 5'h00;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_defaults();
        $display("defaults test done");
        t_wake_table();
        $display("wake table test done");
        t_lan_enables();
        $display("lan enable test done");
        t_phy_mode();
        $display("phy mode test done");
        t_pending();
        $display("pending test done");
        t_bus_reset();
        $display("bus reset test done");
        stop_test();
    end

    // Cuts a hang short well beyond the expected run length.
    initial begin
        repeat (30000) @(posedge ref_clk);
        $display("Error at %0t: watchdog expired", $time);
        fails++;
        stop_test();
    end
endmodule
